// ### sso_seq_status.sv
// servo sequence-signal logic: data-source choice, ready outputs,
// in-position, speed limit, teaching overwrite, brake timing, alarm latch.
// assumes discrete inputs and servo-loop status are synchronous to pclk;
// apb master drives the register file.
`timescale 1ns/1ps
module sso_seq_status
    import sso_pkg::*;
#(
    parameter int SPD_W = 16,
    parameter int CNT_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // discrete inputs from host sequence controller
    input wire logic servo_enable_in,
    input wire logic forced_stop_in,
    input wire logic coast_request,
    input wire logic start_in,
    input wire logic data_source_select,
    input wire logic alarm_clear_in,
    input wire logic [2:0] multistep_speed_sel,
    // status from the servo core
    input wire logic protect_trip,
    input wire logic alarm_cause_present,
    input wire logic cpu_healthy,
    input wire logic [2:0] mains_powered,
    input wire logic motion_active,
    input wire logic [SPD_W-1:0] motor_speed_abs,
    input wire logic [SPD_W-1:0] deviation_abs,
    input wire logic teaching_active,
    // outputs
    output logic use_table_data,
    output logic drive_prepared,
    output logic control_ok,
    output logic position_settled,
    output logic speed_limit_hit,
    output logic overwrite_done,
    output logic brake_timing,
    output logic alarm_detect,
    output logic irq
);

    // one packed word holds every flop
    typedef struct packed {
        // apb settings
        logic [SSO_CTRL_W-1:0] ctrl;
        logic [SPD_W-1:0] zspd;
        logic [SPD_W-1:0] devw;
        logic [SPD_W-1:0] maxspd;
        logic [SPD_W-1:0] tqspd;
        logic [SSO_MSPD_N-1:0][SPD_W-1:0] mspd;
        logic [CNT_W-1:0] shot_time;
        logic [CNT_W-1:0] brk_dly;
        // down-counters, zero = expired
        logic [CNT_W-1:0] shot_cnt;
        logic [CNT_W-1:0] hold_cnt;
        // interrupt state
        logic [SSO_IRQ_W-1:0] irq_st;
        logic [SSO_IRQ_W-1:0] irq_mask;
        // setup-cycle read word
        logic [31:0] rdata;
        logic slverr;
        logic alarm;
        // edge history
        logic clr_d;
        logic start_d;
        logic servo_d;
        logic inpos_d;
        // output flops
        logic use_table;
        logic settled;
        logic drive;
        logic ctrl_ok;
        logic spd_hit;
        logic ovwr;
        logic brake;
    } sso_state_t;

    sso_state_t state_reg;
    sso_state_t state_next;

    // control views
    logic fmt;
    logic tq_src;
    logic [1:0] mode;
    logic ds_mapped;
    logic bk_mapped;

    // bus decode
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_val;

    // settle, limit and ready terms
    logic [SPD_W-1:0] spd_limit;
    logic spd_ok;
    logic dev_ok;
    logic inpos;
    logic hold_on;
    logic base_ok;
    logic ctrl_ok_now;
    logic [7:0] status_word;

    // control field split
    // mode 3 acts as speed control
    assign fmt = state_reg.ctrl[SSO_CTRL_FMT_BIT];
    assign tq_src = state_reg.ctrl[SSO_CTRL_TQSRC_BIT];
    assign mode = state_reg.ctrl[SSO_CTRL_MODE_LSB +: 2];
    assign ds_mapped = state_reg.ctrl[SSO_CTRL_DSMAP_BIT];
    assign bk_mapped = state_reg.ctrl[SSO_CTRL_BKMAP_BIT];

    // apb decode; zero wait states, read data latched in the setup cycle
    // the mux settles before setup, so access never waits
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = state_reg.slverr;

    // status word for polling
    assign status_word = {state_reg.use_table, state_reg.ovwr,
                          state_reg.brake, state_reg.spd_hit,
                          state_reg.settled, state_reg.drive,
                          state_reg.ctrl_ok, state_reg.alarm};

    // read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            SSO_CTRL_OFS: rd_val[SSO_CTRL_W-1:0] = state_reg.ctrl;
            SSO_ZSPD_OFS: rd_val[SPD_W-1:0] = state_reg.zspd;
            SSO_DEVW_OFS: rd_val[SPD_W-1:0] = state_reg.devw;
            SSO_SHOT_OFS: rd_val[CNT_W-1:0] = state_reg.shot_time;
            SSO_MAXSPD_OFS: rd_val[SPD_W-1:0] = state_reg.maxspd;
            SSO_TQSPD_OFS: rd_val[SPD_W-1:0] = state_reg.tqspd;
            SSO_BRKDLY_OFS: rd_val[CNT_W-1:0] = state_reg.brk_dly;
            SSO_STATUS_OFS: rd_val[7:0] = status_word;
            SSO_IRQ_STAT_OFS: rd_val[SSO_IRQ_W-1:0] = state_reg.irq_st;
            SSO_IRQ_MASK_OFS: rd_val[SSO_IRQ_W-1:0] = state_reg.irq_mask;
            default: begin
                // multistep window
                mapped = 1'b0;
                for (int i = 0; i < SSO_MSPD_N; i++) begin
                    if (paddr == SSO_MSPD_OFS + 8'(4 * i)) begin
                        rd_val[SPD_W-1:0] = state_reg.mspd[i];
                        mapped = 1'b1;
                    end
                end
            end
        endcase
    end

    // speed limit per mode; torque mode may take the multistep entry
    // limitation: the select is live, not held
    always_comb begin
        if (mode == SSO_MODE_TRQ) begin
            if (tq_src) begin
                spd_limit = state_reg.mspd[multistep_speed_sel];
            end else begin
                spd_limit = state_reg.tqspd;
            end
        end else begin
            spd_limit = state_reg.maxspd;
        end
    end

    // in-position windows
    // inclusive: equal to the setting is inside
    assign spd_ok = motor_speed_abs <= state_reg.zspd;
    assign dev_ok = deviation_abs <= state_reg.devw;
    assign inpos = spd_ok & dev_ok;

    // states where position control holds settled on regardless of motion
    // idle states show as no motion
    assign hold_on = ~motion_active | ~servo_enable_in | ~forced_stop_in;

    // readiness chains use the latched alarm
    // both chains drop together on stop or coast
    assign ctrl_ok_now = forced_stop_in & ~coast_request & ~state_reg.alarm
                         & cpu_healthy & (&mains_powered);
    assign base_ok = forced_stop_in & ~coast_request & ~state_reg.alarm
                     & ctrl_ok_now;

    // next-state logic for the whole block
    always_comb begin
        logic [SSO_IRQ_W-1:0] ev;
        logic [SSO_IRQ_W-1:0] clr;
        ev = '0;
        clr = '0;
        state_next = state_reg;

        // register writes take effect at the access edge
        // status is read-only
        if (wr_en) begin
            case (paddr)
                SSO_CTRL_OFS: state_next.ctrl = pwdata[SSO_CTRL_W-1:0];
                SSO_ZSPD_OFS: state_next.zspd = pwdata[SPD_W-1:0];
                SSO_DEVW_OFS: state_next.devw = pwdata[SPD_W-1:0];
                SSO_SHOT_OFS: state_next.shot_time = pwdata[CNT_W-1:0];
                SSO_MAXSPD_OFS: state_next.maxspd = pwdata[SPD_W-1:0];
                SSO_TQSPD_OFS: state_next.tqspd = pwdata[SPD_W-1:0];
                SSO_BRKDLY_OFS: state_next.brk_dly = pwdata[CNT_W-1:0];
                SSO_IRQ_STAT_OFS: clr = pwdata[SSO_IRQ_W-1:0];
                SSO_IRQ_MASK_OFS:
                    state_next.irq_mask = pwdata[SSO_IRQ_W-1:0];
                default: begin
                    for (int i = 0; i < SSO_MSPD_N; i++) begin
                        if (paddr == SSO_MSPD_OFS + 8'(4 * i)) begin
                            state_next.mspd[i] = pwdata[SPD_W-1:0];
                        end
                    end
                end
            endcase
        end
        if (rd_setup) begin
            state_next.rdata = rd_val;
            state_next.slverr = ~mapped;
        end

        // edge history of the discrete inputs
        // discrete-input histories reset to idle low, inpos_d resets high
        state_next.start_d = start_in;
        state_next.clr_d = alarm_clear_in;
        state_next.servo_d = servo_enable_in;
        state_next.inpos_d = inpos;

        // data source: taken only at start edge, live value wins a tie
        // unmapped select reads low
        if (start_in & ~state_reg.start_d) begin
            state_next.use_table = data_source_select & ds_mapped;
        end

        // alarm latch: a trip in the clear cycle keeps the alarm set
        if (protect_trip) begin
            state_next.alarm = 1'b1;
        end else if (alarm_clear_in & ~state_reg.clr_d
                     & ~alarm_cause_present) begin
            state_next.alarm = 1'b0;
        end
        if (protect_trip & ~state_reg.alarm) begin
            ev[SSO_IRQ_ALARM] = 1'b1;
        end

        state_next.ctrl_ok = ctrl_ok_now;

        // drive ready with hold-off after servo off
        // hold starts only from an active drive,
        // so a drop while not ready never raises it
        if (!base_ok) begin
            state_next.hold_cnt = '0;
            state_next.drive = 1'b0;
        end else if (servo_enable_in) begin
            state_next.hold_cnt = '0;
            state_next.drive = 1'b1;
        end else begin
            if (state_reg.servo_d & state_reg.drive) begin
                state_next.hold_cnt = state_reg.brk_dly;
            end else if (state_reg.hold_cnt != '0) begin
                state_next.hold_cnt = state_reg.hold_cnt - 1'b1;
            end
            state_next.drive = state_next.hold_cnt != '0;
        end
        if (state_reg.drive & ~state_next.drive) begin
            ev[SSO_IRQ_DRVOFF] = 1'b1;
        end

        // brake timing follows servo-on directly, no hold-off
        state_next.brake = bk_mapped & servo_enable_in & base_ok;

        // single-shot timer, restarted on each entry into position
        // limitation: chatter restarts the shot
        if (!dev_ok) begin
            state_next.shot_cnt = '0;
        end else if (inpos & ~state_reg.inpos_d) begin
            state_next.shot_cnt = state_reg.shot_time;
        end else if (state_reg.shot_cnt != '0) begin
            state_next.shot_cnt = state_reg.shot_cnt - 1'b1;
        end

        // in-position output selection
        // priority: mode, alarm, idle, format
        if (mode != SSO_MODE_POS) begin
            state_next.settled = 1'b1;
        end else if (state_reg.alarm) begin
            state_next.settled = 1'b0;
        end else if (hold_on) begin
            state_next.settled = 1'b1;
        end else if (fmt == SSO_FMT_LEVEL) begin
            state_next.settled = inpos;
        end else begin
            state_next.settled = state_next.shot_cnt != '0;
        end
        if (state_next.settled & ~state_reg.settled) begin
            ev[SSO_IRQ_SETTLE] = 1'b1;
        end

        // speed limit and teaching flags
        // equal to the limit counts as reached
        state_next.spd_hit = motor_speed_abs >= spd_limit;
        if (state_next.spd_hit & ~state_reg.spd_hit) begin
            ev[SSO_IRQ_SPDHIT] = 1'b1;
        end
        state_next.ovwr = teaching_active;

        // sticky status: a new event beats a same-cycle clear
        // software cannot lose an event
        state_next.irq_st = (state_reg.irq_st & ~clr) | ev;
    end

    // single register for all state; settled starts on in level format
    // reset branch: constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.ctrl <= SSO_CTRL_RST;
            state_reg.zspd <= SPD_W'(SSO_ZSPD_RST);
            state_reg.devw <= SPD_W'(SSO_DEVW_RST);
            state_reg.maxspd <= SPD_W'(SSO_MAXSPD_RST);
            state_reg.tqspd <= SPD_W'(SSO_TQSPD_RST);
            state_reg.mspd <= '{default: SPD_W'(SSO_MSPD_RST)};
            state_reg.shot_time <= CNT_W'(SSO_SHOT_RST);
            state_reg.brk_dly <= CNT_W'(SSO_BRKDLY_RST);
            state_reg.settled <= 1'b1;
            state_reg.inpos_d <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    // irq: flop operands only, no glitch
    assign use_table_data = state_reg.use_table;
    assign drive_prepared = state_reg.drive;
    assign control_ok = state_reg.ctrl_ok;
    assign position_settled = state_reg.settled;
    assign speed_limit_hit = state_reg.spd_hit;
    assign overwrite_done = state_reg.ovwr;
    assign brake_timing = state_reg.brake;
    assign alarm_detect = state_reg.alarm;
    assign irq = |(state_reg.irq_st & state_reg.irq_mask);

endmodule : sso_seq_status

// ### sso_pkg.sv
// package for the servo sequence/status output block: register map,
// field positions, reset values and mode codes.
// assumes a 32-bit apb slave with byte addresses on word boundaries.
package sso_pkg;

    // register byte offsets
    localparam logic [7:0] SSO_CTRL_OFS = 8'h00;
    localparam logic [7:0] SSO_ZSPD_OFS = 8'h04;
    localparam logic [7:0] SSO_DEVW_OFS = 8'h08;
    localparam logic [7:0] SSO_SHOT_OFS = 8'h0C;
    localparam logic [7:0] SSO_MAXSPD_OFS = 8'h10;
    localparam logic [7:0] SSO_TQSPD_OFS = 8'h14;
    localparam logic [7:0] SSO_BRKDLY_OFS = 8'h18;
    localparam logic [7:0] SSO_STATUS_OFS = 8'h1C;
    localparam logic [7:0] SSO_IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] SSO_IRQ_MASK_OFS = 8'h24;
    localparam logic [7:0] SSO_MSPD_OFS = 8'h40; // 8 words, 0x40..0x5C

    // control register fields
    localparam int SSO_CTRL_W = 6;
    localparam int SSO_CTRL_FMT_BIT = 0;    // settle_format_sel
    localparam int SSO_CTRL_TQSRC_BIT = 1;  // torque_limit_source_sel
    localparam int SSO_CTRL_MODE_LSB = 2;   // control mode, 2 bits
    localparam int SSO_CTRL_DSMAP_BIT = 4;  // data_source_select mapped
    localparam int SSO_CTRL_BKMAP_BIT = 5;  // brake timing mapped
    localparam logic [5:0] SSO_CTRL_RST = 6'h30;

    // control modes
    localparam logic [1:0] SSO_MODE_POS = 2'h0;
    localparam logic [1:0] SSO_MODE_SPD = 2'h1;
    localparam logic [1:0] SSO_MODE_TRQ = 2'h2;

    // settle formats
    localparam logic SSO_FMT_LEVEL = 1'b0;
    localparam logic SSO_FMT_SHOT = 1'b1;

    // status register bits
    localparam int SSO_ST_ALARM = 0;
    localparam int SSO_ST_CTRLOK = 1;
    localparam int SSO_ST_DRIVE = 2;
    localparam int SSO_ST_SETTLED = 3;
    localparam int SSO_ST_SPDHIT = 4;
    localparam int SSO_ST_BRAKE = 5;
    localparam int SSO_ST_OVWR = 6;
    localparam int SSO_ST_TABLE = 7;

    // interrupt status bits
    localparam int SSO_IRQ_W = 4;
    localparam int SSO_IRQ_ALARM = 0;   // alarm latched
    localparam int SSO_IRQ_SETTLE = 1;  // position_settled rose
    localparam int SSO_IRQ_SPDHIT = 2;  // speed limit reached
    localparam int SSO_IRQ_DRVOFF = 3;  // drive_prepared fell

    // reset values of timing and window registers (in pclk ticks / units)
    localparam logic [15:0] SSO_ZSPD_RST = 16'h0032;
    localparam logic [15:0] SSO_DEVW_RST = 16'h0064;
    localparam logic [15:0] SSO_MAXSPD_RST = 16'h1388;
    localparam logic [15:0] SSO_TQSPD_RST = 16'h1388;
    localparam logic [15:0] SSO_MSPD_RST = 16'h0000;
    localparam logic [23:0] SSO_SHOT_RST = 24'h00_03E8;
    localparam logic [23:0] SSO_BRKDLY_RST = 24'h00_03E8;

    // table depth of multistep speed settings (3 select bits)
    localparam int SSO_MSPD_N = 8;

endpackage : sso_pkg

// ### sso_host_model.sv
// host sequence controller model: drives the discrete sequence inputs.
// assumes the bench posts a command word; pins move only after pclk edges.
`timescale 1ns/1ps
module sso_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] cmd,
    output logic [5:0] pins
);
    // output latch of the controller; quiet while the amplifier resets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= 6'h00;
        end else begin
            pins <= cmd;
        end
    end
endmodule : sso_host_model

// ### sso_seq_status_assertions.sv
// port checker for the servo sequence/status block.
// assumes one pclk domain; the setting registers are not visible here,
// so only relations that hold for every setting are checked.
`timescale 1ns/1ps
module sso_seq_status_assertions
    import sso_pkg::*;
#(
    parameter int SPD_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic servo_enable_in,
    input wire logic forced_stop_in,
    input wire logic coast_request,
    input wire logic start_in,
    input wire logic data_source_select,
    input wire logic alarm_clear_in,
    input wire logic protect_trip,
    input wire logic alarm_cause_present,
    input wire logic cpu_healthy,
    input wire logic [2:0] mains_powered,
    input wire logic [SPD_W-1:0] motor_speed_abs,
    input wire logic teaching_active,
    input wire logic use_table_data,
    input wire logic drive_prepared,
    input wire logic control_ok,
    input wire logic speed_limit_hit,
    input wire logic overwrite_done,
    input wire logic brake_timing,
    input wire logic alarm_detect
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // start edges and servo drops, the events the outputs follow
    sequence start_low_s;
        !start_in ##1 (start_in && !data_source_select);
    endsequence
    sequence servo_drop_s;
        servo_enable_in ##1 !servo_enable_in;
    endsequence
    AST_TABLE_EDGE: assert property ($changed(use_table_data) |->
        $past(start_in) && !$past(start_in, 2))
        else $error("table choice moved without a start edge");
    AST_TABLE_LOW: assert property (start_low_s |=> !use_table_data)
        else $error("low select at start did not pick immediate data");
    AST_BRAKE_OFF: assert property (servo_drop_s |=> !brake_timing)
        else $error("brake timing stayed on after servo off");
    AST_ALARM_SET: assert property (protect_trip |=> alarm_detect)
        else $error("trip did not latch the alarm");
    AST_ALARM_CLR: assert property ($fell(alarm_detect) |->
        $past(alarm_clear_in) && !$past(alarm_clear_in, 2) &&
        !$past(protect_trip) && !$past(alarm_cause_present))
        else $error("alarm cleared without a clean clear edge");
    AST_CTRL_OK: assert property (control_ok |-> $past(forced_stop_in) &&
        !$past(coast_request) && $past(cpu_healthy) &&
        ($past(mains_powered) == 3'h7))
        else $error("control ok without its conditions");
    AST_DRIVE_ROSE: assert property ($rose(drive_prepared) |->
        $past(servo_enable_in) && $past(forced_stop_in) &&
        !$past(coast_request))
        else $error("drive ready rose without its conditions");
    AST_SPD_MAX: assert property ((&motor_speed_abs) |=> speed_limit_hit)
        else $error("full speed did not flag the limit");
    AST_OVWR: assert property (teaching_active [*2] |-> overwrite_done)
        else $error("overwrite done off while teaching");
endmodule : sso_seq_status_assertions

bind sso_seq_status sso_seq_status_assertions #(.SPD_W(SPD_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .servo_enable_in(servo_enable_in),
    .forced_stop_in(forced_stop_in), .coast_request(coast_request),
    .start_in(start_in), .data_source_select(data_source_select),
    .alarm_clear_in(alarm_clear_in), .protect_trip(protect_trip),
    .alarm_cause_present(alarm_cause_present), .cpu_healthy(cpu_healthy),
    .mains_powered(mains_powered), .motor_speed_abs(motor_speed_abs),
    .teaching_active(teaching_active), .use_table_data(use_table_data),
    .drive_prepared(drive_prepared), .control_ok(control_ok),
    .speed_limit_hit(speed_limit_hit), .overwrite_done(overwrite_done),
    .brake_timing(brake_timing), .alarm_detect(alarm_detect));

// ### sso_seq_status_bench.sv
// self-checking bench for the servo sequence/status block.
// assumes the host model on the discrete inputs and an apb master here.
`timescale 1ns/1ps
module sso_seq_status_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, err, trip = 0, cause = 0, cpu = 1;
    logic motion = 0, teach = 0;
    logic [5:0] cmd = '0, pins;
    logic [2:0] mss = '0, mains = 3'h7;
    logic [15:0] spd = '0, dev = '0;
    logic tbl, drv, cok, set, shit, ovw, brk, alm, irq;
    int failures = 0, num_checks = 0, cycles = 0, seed = 6293, i, n, e, ok;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h24};
    logic [31:0] rv [8] = '{32'h30, 32'h32, 32'h64, 32'h3E8, 32'h1388,
        32'h1388, 32'h3E8, 32'h0};
    logic [5:0] dc [5] = '{6'h03, 6'h1B, 6'h0B, 6'h03, 6'h0B};
    logic dt [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] sc [6] = '{8'h30, 8'h30, 8'h38, 8'h38, 8'h3A, 8'h3A};
    logic [15:0] sv [6] = '{16'h1388, 16'h1387, 16'h0064, 16'h0063,
        16'h012C, 16'h012B};

    always #5 pclk = ~pclk;
    sso_host_model host (.pclk(pclk), .presetn(presetn), .cmd(cmd),
        .pins(pins));
    sso_seq_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_enable_in(pins[0]), .forced_stop_in(pins[1]),
        .coast_request(pins[2]), .start_in(pins[3]),
        .data_source_select(pins[4]), .alarm_clear_in(pins[5]),
        .multistep_speed_sel(mss), .protect_trip(trip),
        .alarm_cause_present(cause), .cpu_healthy(cpu),
        .mains_powered(mains), .motion_active(motion),
        .motor_speed_abs(spd), .deviation_abs(dev),
        .teaching_active(teach), .use_table_data(tbl),
        .drive_prepared(drv), .control_ok(cok), .position_settled(set),
        .speed_limit_hit(shit), .overwrite_done(ovw), .brake_timing(brk),
        .alarm_detect(alm), .irq(irq));

    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; waits on pready rather than assuming zero waits
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // sample just after an edge so registered outputs have landed
    task automatic step(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : step

    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // setting registers at reset, an unmapped word, masked interrupt
        for (i = 0; i < 8; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(r, rv[i]);
        end
        apb(1'b0, 8'h30, 32'h0);
        check(err, 1'b1);
        check(irq, 1'b0);
        // drive hold after servo off, for a real and a zero delay
        for (i = 4; i >= 0; i -= 4) begin
            apb(1'b1, 8'h18, i);
            cmd <= 6'h03;
            step(6);
            check(drv, 1'b1);
            @(posedge pclk);
            cmd <= 6'h02;
            while (brk !== 1'b0) step(1);
            n = 0;
            while (drv === 1'b1) begin
                step(1);
                n++;
            end
            check(n, i);
        end
        // random ready conditions against the integer model
        for (i = 0; i < 16; i++) begin
            e = $random(seed);
            @(posedge pclk);
            cmd <= {3'h0, e[2] & e[5], e[1] | e[4], e[0] | e[3]};
            cpu <= e[6] | e[7];
            mains <= {e[8] | e[9], 2'b11};
            ok = (e[1] | e[4]) && !(e[2] & e[5]) && (e[6] | e[7]) &&
                (e[8] | e[9]);
            step(6);
            check(cok, ok);
            check(drv, ok && (e[0] | e[3]));
        end
        @(posedge pclk);
        cpu <= 1'b1;
        mains <= 3'h7;
        // brake timing with its output unmapped, then mapped again
        apb(1'b1, 8'h00, 32'h10);
        cmd <= 6'h03;
        step(6);
        check(brk, 1'b0);
        apb(1'b1, 8'h00, 32'h30);
        step(4);
        check(brk, 1'b1);
        // table choice moves only on a start edge, new select wins
        for (i = 0; i < 5; i++) begin
            @(posedge pclk);
            cmd <= dc[i];
            step(6);
            check(tbl, dt[i]);
        end
        apb(1'b1, 8'h00, 32'h20);
        cmd <= 6'h03;
        step(4);
        @(posedge pclk);
        cmd <= 6'h1B;
        step(6);
        check(tbl, 1'b0);
        cmd <= 6'h03;
        apb(1'b1, 8'h00, 32'h30);
        // level format against the speed and deviation windows
        motion <= 1'b1;
        for (i = 0; i < 10; i++) begin
            e = $random(seed);
            @(posedge pclk);
            spd <= e[5:0];
            dev <= e[13:7];
            step(4);
            check(set, (e[5:0] <= 50) && (e[13:7] <= 100));
        end
        @(posedge pclk);
        dev <= 16'h00C8;
        for (i = 0; i < 3; i++) begin
            apb(1'b1, 8'h00, 32'h30 + 4 * i);
            step(4);
            check(set, i != 0);
        end
        apb(1'b1, 8'h00, 32'h30);
        motion <= 1'b0;
        step(4);
        check(set, 1'b1);
        // single shot: exact width, then forced off by deviation
        apb(1'b1, 8'h0C, 32'h4);
        apb(1'b1, 8'h00, 32'h31);
        motion <= 1'b1;
        step(4);
        check(set, 1'b0);
        @(posedge pclk);
        dev <= 16'h0000;
        spd <= 16'h0000;
        while (set !== 1'b1) step(1);
        n = 0;
        while (set === 1'b1) begin
            step(1);
            n++;
        end
        check(n, 4);
        apb(1'b1, 8'h0C, 32'h14);
        dev <= 16'h00C8;
        step(4);
        @(posedge pclk);
        dev <= 16'h0000;
        while (set !== 1'b1) step(1);
        @(posedge pclk);
        dev <= 16'h00C8;
        step(3);
        check(set, 1'b0);
        // speed limit per mode and from the multistep table
        apb(1'b1, 8'h14, 32'h64);
        apb(1'b1, 8'h54, 32'h12C);
        mss <= 3'h5;
        for (i = 0; i < 6; i++) begin
            apb(1'b1, 8'h00, sc[i]);
            spd <= sv[i];
            step(4);
            check(shit, i % 2 == 0);
        end
        @(posedge pclk);
        spd <= 16'hFFFF;
        step(2);
        check(shit, 1'b1);
        // alarm latch, clear refused while the cause stays, interrupt
        @(posedge pclk);
        spd <= 16'h0000;
        dev <= 16'h0000;
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b1, 8'h00, 32'h30);
        trip <= 1'b1;
        cause <= 1'b1;
        step(4);
        check({alm, irq, set, cok, drv}, 5'b11000);
        @(posedge pclk);
        trip <= 1'b0;
        cmd <= 6'h23;
        step(4);
        check(alm, 1'b1);
        @(posedge pclk);
        cmd <= 6'h03;
        cause <= 1'b0;
        step(4);
        @(posedge pclk);
        cmd <= 6'h23;
        step(4);
        check(alm, 1'b0);
        apb(1'b1, 8'h20, 32'hF);
        step(1);
        check(irq, 1'b0);
        // teaching entry
        @(posedge pclk);
        teach <= 1'b1;
        step(4);
        check(ovw, 1'b1);
        give_verdict();
    end
endmodule : sso_seq_status_bench
